/* rtl/pao_defines.vh */
// pao_defines.vh: shared constants for the converter output logic
// assumes inclusion by bare name from design files under rtl/
`ifndef PAO_DEFINES_VH
`define PAO_DEFINES_VH
`define PAO_WIDTH        12
`define PAO_LATENCY      10
`define PAO_POS_FS       12'h7FF
`define PAO_NEG_FS       12'h800
`define PAO_CLK_PERIOD_PS 8000
`define PAO_SETTLE_NS    200
`define PAO_SETTLE_CYC   10
`define PAO_MIN_RATE_NS  1000
`endif

/* rtl/pao_delay_line.v */
// pao_delay_line.v: fixed-depth register pipeline for sample plus flag
// assumes one clock; stage advances on every strobe-qualified cycle
`timescale 1ns/1ps
module pao_delay_line #(
  parameter WIDTH = 13,
  parameter DEPTH = 9
) (
  input  wire             core_clk, // system clock
  input  wire             nrst,     // sync reset, active low
  input  wire             adv,      // advance one stage
  input  wire [WIDTH-1:0] din,      // stage input
  output wire [WIDTH-1:0] dout      // last stage output
);
  reg [WIDTH-1:0] stage_reg [0:DEPTH-1];
  integer i;
  always @(posedge core_clk) begin
    if (!nrst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage_reg[i] <= {WIDTH{1'b0}};
      end
    end else if (adv) begin
      stage_reg[0] <= din;
      for (i = 1; i < DEPTH; i = i + 1) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end
  assign dout = stage_reg[DEPTH-1];
endmodule

/* rtl/pao_output_logic.v */
// pao_output_logic.v: saturating twos-complement output pipeline
// assumes sample strobe and raw code are synchronous to core_clk
//
// Functional notes
// RQ1 - output samples are signed twos-complement words
// RQ2 - over-range flag low whenever the output sample is in range
// RQ3 - flag high in any cycle the output equals +2047 or -2048
// RQ4 - flag recomputed each sample and delayed exactly like the data
// RQ5 - flag stays high while samples remain at full scale
// RQ6 - samples clamp at full scale instead of wrapping
// RQ7 - registered outputs, ten strobe cycles from sample to output
// RQ8 - outputs change only right after a strobe rising edge; out_valid changes with the settle tracker instead
// RQ9 - strobe rate must stay at or above 1 MSPS
// RQ10 - capture ignores output until 200 ns and 10 strobes elapse
// RQ11 - capture takes sample bits and flag together as one word
`timescale 1ns/1ps
`include "pao_defines.vh"
module pao_output_logic #(
  parameter LATENCY    = `PAO_LATENCY,
  parameter SETTLE_CYC = `PAO_SETTLE_CYC
) (
  input  wire        core_clk,    // 125 MHz system clock
  input  wire        nrst,        // sync reset, active low
  input  wire        strobe,      // sample strobe level
  input  wire [13:0] raw_code,    // signed raw conversion, wider range
  output reg  [11:0] sample_bits, // twos-complement output word
  output reg         over_range,  // full-scale flag, aligned to word
  output wire        out_valid    // settle window over
);

  // settle window: 200 ns rounded up to whole core_clk periods
  localparam integer SETTLE_CLKS =
    (`PAO_SETTLE_NS * 1000 + `PAO_CLK_PERIOD_PS - 1) / `PAO_CLK_PERIOD_PS;
  // slowest legal sample period in core_clk periods
  localparam integer GAP_CLKS    =
    (`PAO_MIN_RATE_NS * 1000) / `PAO_CLK_PERIOD_PS;
  localparam integer PIPE_W      = 13;
  localparam [11:0]  POS_FS      = `PAO_POS_FS;
  localparam [11:0]  NEG_FS      = `PAO_NEG_FS;
  localparam [4:0]   EDGE_GOAL   = SETTLE_CYC[4:0];
  localparam [7:0]   TIME_GOAL   = SETTLE_CLKS[7:0];
  localparam [7:0]   GAP_GOAL    = GAP_CLKS[7:0];

  // settle tracker states, one-hot
  localparam [2:0]   ST_COLD     = 3'h1;
  localparam [2:0]   ST_WARM     = 3'h2;
  localparam [2:0]   ST_READY    = 3'h4;

  // clamp wider signed value to the 12-bit code range
  function [11:0] sat12;
    input [13:0] v;
    begin
      if (!v[13] && (v[12:11] != 2'b00)) begin
        sat12 = POS_FS;
      end else if (v[13] && (v[12:11] != 2'b11)) begin
        sat12 = NEG_FS;
      end else begin
        sat12 = v[11:0];
      end
    end
  endfunction

  // true at either end of the code range
  function is_fs;
    input [11:0] w;
    begin
      is_fs = (w == POS_FS) || (w == NEG_FS);
    end
  endfunction

  // true once a counter has reached its goal
  // widened to 8 bits so all counters share it
  function reached;
    input [7:0] cnt;
    input [7:0] goal;
    begin
      reached = (cnt >= goal);
    end
  endfunction

  // pipeline word: flag above the sample bits
  reg  [2:0]        settle_state_reg;
  reg  [2:0]        settle_state_next;
  reg               strobe_d_reg;
  wire              strobe_rise;
  wire [11:0]       sat_word;
  wire              sat_flag;
  wire [PIPE_W-1:0] head;
  wire [PIPE_W-1:0] tail;
  reg  [4:0]        edge_cnt_reg;
  reg  [7:0]        time_cnt_reg;
  reg  [7:0]        gap_cnt_reg;
  wire              strobe_lost;
  wire              edge_done;
  wire              time_done;

  // a held-high strobe counts once; the pin idles low after reset,
  // so the detector register clears low and no false edge follows
  assign strobe_rise = strobe & ~strobe_d_reg;

  always @(posedge core_clk) begin
    if (!nrst) begin
      strobe_d_reg <= 1'b0;
    end else begin
      strobe_d_reg <= strobe;
    end
  end

  // clamp first, then flag the clamped word, so the flag marks the code
  // really output; an exact full-scale code in range also sets it
  assign sat_word = sat12(raw_code); // RQ6 RQ1
  assign sat_flag = is_fs(sat_word); // RQ3 RQ2
  assign head     = {sat_flag, sat_word}; // RQ4

  // LATENCY stages advance on sample edges only; the output register
  // below takes the last one, so a sample shows at the LATENCY-th
  // following edge; reset zeros make early words read as mid-scale
  pao_delay_line #(.WIDTH(PIPE_W), .DEPTH(LATENCY)) u_dly (
    .core_clk (core_clk),
    .nrst     (nrst),
    .adv      (strobe_rise),
    .din      (head),
    .dout     (tail)
  );

  // word and flag move in one register so they never disagree
  // reset clears to mid-scale zero with the flag low
  always @(posedge core_clk) begin
    if (!nrst) begin
      sample_bits <= 12'h000;
      over_range  <= 1'b0;
    end else if (strobe_rise) begin // RQ8
      sample_bits <= tail[11:0]; // RQ7
      over_range  <= tail[12];   // RQ4 RQ5
    end
  end

  // a gap longer than the slowest legal sample period means the strobe
  // was interrupted; the counter stops there until the next edge
  // so it can never wrap back into the legal range
  always @(posedge core_clk) begin
    if (!nrst) begin
      gap_cnt_reg <= 8'h00;
    end else if (strobe_rise) begin
      gap_cnt_reg <= 8'h00;
    end else if (!strobe_lost) begin
      gap_cnt_reg <= gap_cnt_reg + 8'h01;
    end
  end
  // an interruption demands a fresh settle window
  assign strobe_lost = reached(gap_cnt_reg, GAP_GOAL);

  // strobe edges seen since reset or resume, saturating at the goal
  always @(posedge core_clk) begin
    if (!nrst) begin
      edge_cnt_reg <= 5'h00;
    end else if (strobe_lost) begin
      edge_cnt_reg <= 5'h00;
    end else if (strobe_rise && !edge_done) begin
      edge_cnt_reg <= edge_cnt_reg + 5'h01; // RQ10
    end
  end

  // core_clk periods since reset or resume stand in for settle time
  // limitation: power-up itself is not seen, only the reset after it
  always @(posedge core_clk) begin
    if (!nrst) begin
      time_cnt_reg <= 8'h00;
    end else if (strobe_lost) begin
      time_cnt_reg <= 8'h00;
    end else if (!time_done) begin
      time_cnt_reg <= time_cnt_reg + 8'h01; // RQ10
    end
  end

  // both the time and the strobe count must pass
  assign edge_done = reached({3'h0, edge_cnt_reg}, {3'h0, EDGE_GOAL});
  assign time_done = reached(time_cnt_reg, TIME_GOAL);

  // WARM only records that one of the two goals is met
  always @(posedge core_clk) begin
    if (!nrst) begin
      settle_state_reg <= ST_COLD;
    end else begin
      settle_state_reg <= settle_state_next;
    end
  end

  // an interruption drops straight back to cold from any state
  always @* begin
    settle_state_next = settle_state_reg;
    if (strobe_lost) begin
      settle_state_next = ST_COLD;
    end else begin
      case (settle_state_reg)
        ST_COLD: begin
          if (edge_done && time_done) begin
            settle_state_next = ST_READY;
          end else if (edge_done || time_done) begin
            settle_state_next = ST_WARM;
          end
        end
        ST_WARM: begin
          if (edge_done && time_done) begin
            settle_state_next = ST_READY;
          end
        end
        ST_READY: begin
          settle_state_next = ST_READY;
        end
        default: begin
          settle_state_next = ST_COLD;
        end
      endcase
    end
  end

  // registered, so out_valid rises one clock after both goals are met;
  // it is a hint only, capture logic still applies its own discard
  assign out_valid = (settle_state_reg == ST_READY); // RQ10
endmodule

/* test/pao_cap_model.sv */
// capture model: word and flag taken together two clocks after an edge
`timescale 1ns/1ps
module pao_cap (input wire core_clk, strobe, over_range, // controls
  input wire [11:0] sample_bits, output reg [12:0] cap); // captured word
  reg [2:0] d = 3'h0;
  always @(posedge core_clk) d <= {d[1], strobe & ~d[0], strobe};
  always @(posedge core_clk)
    if (d[2]) cap <= {sample_bits, over_range};
endmodule

/* test/pao_output_logic_props.sv */
// checker: word and flag against strobe edges counted on core_clk
`timescale 1ns/1ps
module pao_props #(parameter LATENCY = 10) (
  input wire core_clk, nrst, strobe, over_range, out_valid, // controls
  input wire [11:0] sample_bits); // output word
  reg s_q;
  reg [4:0] cnt;
  wire r = strobe & ~s_q;
  wire fs = sample_bits == 12'h7FF || sample_bits == 12'h800;
  always @(posedge core_clk) begin
    s_q <= strobe;
    cnt <= nrst ? cnt + {4'h0, r & ~cnt[4]} : 5'h00;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_flag; over_range == fs; endproperty
  a_flag: assert property (p_flag) else $error("flag");
  property p_lat; cnt < LATENCY |-> sample_bits == 12'h000; endproperty
  a_lat: assert property (p_lat) else $error("latency");
  property p_hold;
    !r |=> $stable(sample_bits) && $stable(over_range);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved");
  property p_rise; $rose(over_range) |-> fs; endproperty
  a_rise: assert property (p_rise) else $error("flag rise");
  property p_fall; $fell(over_range) |-> !fs; endproperty
  a_fall: assert property (p_fall) else $error("flag fall");
  property p_low; !fs |-> !over_range; endproperty
  a_low: assert property (p_low) else $error("flag low");
  property p_valid; out_valid |=> out_valid; endproperty
  a_valid: assert property (p_valid) else $error("valid drop");
endmodule
bind pao_output_logic pao_props #(.LATENCY(LATENCY)) u_props (
  .core_clk(core_clk), .nrst(nrst), .strobe(strobe),
  .over_range(over_range), .out_valid(out_valid),
  .sample_bits(sample_bits));

/* test/pipelined_adc_output_logic_tb.sv */
// bench: random words in, captures checked against a queue model
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  bad_count++; $display("ERROR %0t word", $time); end end
module pipelined_adc_output_logic_tb;
  reg core_clk = 0, nrst = 0, strobe = 0;
  reg [13:0] raw_code = 14'h0000;
  wire [11:0] sample_bits;
  wire [12:0] cap;
  wire over_range, out_valid;
  int bad_count = 0, checks_done = 0, v, e, q[$];
  pao_output_logic DUT (.*);
  pao_cap u_cap (.*);
  task end_sim;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #4 core_clk = ~core_clk;
  initial begin
    e = $urandom(32'hF59B4E32);
    repeat (4) @(posedge core_clk);
    #1 nrst = 1;
    for (int i = 0; i < 90; i++) begin
      @(posedge core_clk) #1 e = q.size() > 10 ? q.pop_front() : 0;
      if (i) `CHK(cap, {e[11:0], e == 2047 || e == -2048})
      if (i == 0) `CHK(out_valid, 1'b0)
      raw_code = i < 2 ? 14'h07FF ^ {14{i[0]}} : 14'($urandom);
      v = $signed(raw_code);
      q.push_back(v > 2047 ? 2047 : v < -2048 ? -2048 : v);
      strobe = 1;
      @(posedge core_clk) #1 strobe = 0;
      repeat (2) @(posedge core_clk);
    end
    `CHK(out_valid, 1'b1)
    end_sim;
  end
endmodule
